/* File: rtl/calc_consts.vh */
// Constants used by the command interpreter core, not by its memories.
// Assumes inclusion by bare name from files under rtl/.
`ifndef CALC_CONSTS_VH
`define CALC_CONSTS_VH

// Instruction codes
`define CMD_DEFINE_HANDLER 8'h25
`define CMD_HANDLER_RETURN 8'h26
`define CMD_CALC_TWO_VARS  8'h28
`define CMD_CALC_VAR_ACCU  8'h29

// Operation codes carried in the type field
`define OP_ADD  8'h00
`define OP_SUB  8'h01
`define OP_MUL  8'h02
`define OP_DIV  8'h03
`define OP_MOD  8'h04
`define OP_AND  8'h05
`define OP_OR   8'h06
`define OP_XOR  8'h07
`define OP_NOT  8'h08
`define OP_LOAD 8'h09
`define OP_SWAP 8'h0A
`define OP_COMP 8'h0B

// Reply status codes and addresses
`define ST_OK           8'h64
`define ST_BAD_CHECKSUM 8'h01
`define ST_BAD_CMD      8'h02
`define HOST_ADDR       8'h02

// Interrupt numbers
`define IRQ_TIMER0 8'h00
`define IRQ_GLOBAL 8'hFF

// Frame byte counter end value (nine bytes, 0..8)
`define FRAME_LAST 4'h8

// Comparison flag bit positions
`define FLAG_EQ 0
`define FLAG_LT 1

`endif

/* File: rtl/vector_calc_core.v */
// Standalone command core: handler vectors, handler return, user variable math.
// Assumes host bytes and program instructions are synchronous to clock_i.
`include "calc_consts.vh"

// Functional notes
// - Code 37 stores value as handler address for interrupt number in type.
// - Host-sent vector, return and calc commands answer with status 100.
// - Handler return restores accumulator, X, flags and program counter.
// - Code 38 ends the active handler; bank and value ignored.
// - Vector and return act only from stored program, not host frames.
// - Code 40: type op, bank is var1, value is var2, result to var1.
// - Ops 0..11: add sub mul div mod and or xor not load swap comp.
// - Two-variable math leaves accumulator and X unchanged.
// - Code 41: variable op accumulator, result to variable, value ignored.
// - With accumulator: load, not, swap, subtract act as described.
// - Reply: host addr, target, status, code, four value bytes, checksum.
// - Interrupt number 0 is timer 0; entered on event when enabled and vector 0 has been defined.
// - Number 255 is global enable, never a vector slot.
// - Redefining a vector replaces the older address.
module vector_calc_core #(
	parameter [7:0] DEV_ADDR = 8'h01,
	parameter       DW       = 32
) (
	input  wire          clock_i,
	input  wire          sys_rst_i,
	input  wire [7:0]    rx_byte_i,
	input  wire          rx_valid_i,
	input  wire          instr_valid_i,
	input  wire [7:0]    instr_code_i,
	input  wire [7:0]    instr_type_i,
	input  wire [7:0]    instr_bank_i,
	input  wire [DW-1:0] instr_value_i,
	input  wire          timer0_event_i,
	input  wire          irq_global_en_i,
	input  wire          irq_timer0_en_i,
	input  wire          acc_wr_i,
	input  wire [DW-1:0] acc_wr_data_i,
	input  wire          x_wr_i,
	input  wire [DW-1:0] x_wr_data_i,
	output reg           instr_ready_o,
	output reg  [DW-1:0] acc_o,
	output reg  [DW-1:0] x_o,
	output reg  [1:0]    flags_o,
	output reg  [DW-1:0] pc_o,
	output reg           in_handler_o,
	output reg  [7:0]    tx_byte_o,
	output reg           tx_valid_o
);
	localparam [2:0] S_IDLE  = 3'd0;
	localparam [2:0] S_RD1   = 3'd1;
	localparam [2:0] S_RD2   = 3'd2;
	localparam [2:0] S_EX    = 3'd3;
	localparam [2:0] S_WB2   = 3'd4;
	localparam [2:0] S_IRQ   = 3'd5;
	localparam [2:0] S_REPLY = 3'd6;

	function [7:0] sum8;
		input [63:0] w;
		integer i;
		begin
			sum8 = 8'h00;
			for (i = 0; i < 8; i = i + 1) begin
				sum8 = sum8 + w[i*8 +: 8];
			end
		end
	endfunction

	function [71:0] mk_reply;
		input [7:0] status;
		input [7:0] code;
		reg   [63:0] w;
		begin
			w = {`HOST_ADDR, DEV_ADDR, status, code, 32'h0000_0000};
			mk_reply = {w, sum8(w)};
		end
	endfunction

	function [DW-1:0] calc;
		input [7:0]    op;
		input [DW-1:0] a;
		input [DW-1:0] b;
		begin
			case (op)
			`OP_ADD:  calc = a + b;
			`OP_SUB:  calc = a - b;
			`OP_MUL:  calc = a * b;
			`OP_DIV:  calc = (b == {DW{1'b0}}) ? a : $signed(a) / $signed(b);
			`OP_MOD:  calc = (b == {DW{1'b0}}) ? a : $signed(a) % $signed(b);
			`OP_AND:  calc = a & b;
			`OP_OR:   calc = a | b;
			`OP_XOR:  calc = a ^ b;
			`OP_NOT:  calc = ~b;
			`OP_LOAD: calc = b;
			default:  calc = a;
			endcase
		end
	endfunction

	reg  [2:0]    state_r;
	reg  [3:0]    rx_cnt_r;
	reg  [63:0]   rx_sh_r;
	reg  [71:0]   host_frm_r;
	reg           host_pend_r;
	reg           src_host_r;
	reg  [7:0]    code_r;
	reg  [7:0]    type_r;
	reg  [7:0]    bank_r;
	reg  [DW-1:0] val_r;
	reg  [DW-1:0] op_a_r;
	reg  [71:0]   tx_sh_r;
	reg  [3:0]    tx_cnt_r;
	reg           irq_pend_r;
	reg           vec0_def_r;
	reg  [DW-1:0] sv_acc_r;
	reg  [DW-1:0] sv_x_r;
	reg  [1:0]    sv_flags_r;
	reg  [DW-1:0] sv_pc_r;
	reg  [2:0]    state_nxt;

	wire [DW-1:0] var_rd;
	wire [DW-1:0] vec_rd;
	reg           var_we;
	reg  [7:0]    var_wa;
	reg  [DW-1:0] var_wd;
	reg  [7:0]    var_ra;
	reg           vec_we;

	// Selected request in idle: host frame first, program instruction second
	wire          sel_host = host_pend_r;
	wire [7:0]    sel_code = sel_host ? host_frm_r[63:56] : instr_code_i;
	wire [7:0]    sel_type = sel_host ? host_frm_r[55:48] : instr_type_i;
	wire [7:0]    sel_bank = sel_host ? host_frm_r[47:40] : instr_bank_i;
	wire [DW-1:0] sel_val  = sel_host ? host_frm_r[39:8]  : instr_value_i;
	wire          frm_ok   = sum8(host_frm_r[71:8]) == host_frm_r[7:0];
	wire          frm_done = rx_valid_i && (rx_cnt_r == `FRAME_LAST);
	wire          is_calc  = (sel_code == `CMD_CALC_TWO_VARS) ||
	                         (sel_code == `CMD_CALC_VAR_ACCU);
	wire          take_irq = irq_pend_r && irq_global_en_i && irq_timer0_en_i &&
	                         vec0_def_r && !in_handler_o && !host_pend_r;
	wire          take_ins = instr_valid_i && instr_ready_o && !host_pend_r && !take_irq;
	wire          is_vv    = (code_r == `CMD_CALC_TWO_VARS);
	wire [DW-1:0] ex_a     = op_a_r;
	wire [DW-1:0] ex_b     = is_vv ? var_rd : acc_o;

	word_ram #(.AW(8), .DW(DW)) u_vars (
		.clock_i   (clock_i),
		.sys_rst_i (sys_rst_i),
		.wr_en_i   (var_we),
		.wr_addr_i (var_wa),
		.wr_data_i (var_wd),
		.rd_addr_i (var_ra),
		.rd_data_o (var_rd)
	);

	// Vector table; slot 0 is read continuously for timer 0 entry
	word_ram #(.AW(8), .DW(DW)) u_vectors (
		.clock_i   (clock_i),
		.sys_rst_i (sys_rst_i),
		.wr_en_i   (vec_we),
		.wr_addr_i (sel_type),
		.wr_data_i (sel_val),
		.rd_addr_i (`IRQ_TIMER0),
		.rd_data_o (vec_rd)
	);

	always @* begin
		vec_we = (state_r == S_IDLE) && take_ins && (sel_code == `CMD_DEFINE_HANDLER) &&
		         (sel_type != `IRQ_GLOBAL);
		var_ra = (state_r == S_RD2 && is_vv) ? val_r[7:0] : bank_r;
		var_we = 1'b0;
		var_wa = bank_r;
		var_wd = calc(type_r, ex_a, ex_b);
		if (state_r == S_EX) begin
			if (type_r == `OP_SWAP) begin
				var_we = 1'b1;
				var_wd = ex_b;
			end else if (type_r < `OP_SWAP) begin
				var_we = 1'b1;
			end
		end else if (state_r == S_WB2) begin
			var_we = 1'b1;
			var_wa = val_r[7:0];
			var_wd = op_a_r;
		end
	end

	always @* begin
		state_nxt = state_r;
		case (state_r)
		S_IDLE: begin
			if (sel_host) begin
				if (!frm_ok || !is_calc && sel_code != `CMD_DEFINE_HANDLER &&
				    sel_code != `CMD_HANDLER_RETURN) begin
					state_nxt = S_REPLY;
				end else if (is_calc) begin
					state_nxt = S_RD1;
				end else begin
					state_nxt = S_REPLY;
				end
			end else if (take_irq) begin
				state_nxt = S_IRQ;
			end else if (take_ins && is_calc) begin
				state_nxt = S_RD1;
			end
		end
		S_RD1:   state_nxt = S_RD2;
		S_RD2:   state_nxt = S_EX;
		S_EX: begin
			if (is_vv && type_r == `OP_SWAP) begin
				state_nxt = S_WB2;
			end else begin
				state_nxt = src_host_r ? S_REPLY : S_IDLE;
			end
		end
		S_WB2:   state_nxt = src_host_r ? S_REPLY : S_IDLE;
		S_IRQ:   state_nxt = S_IDLE;
		S_REPLY: state_nxt = (tx_cnt_r == `FRAME_LAST) ? S_IDLE : S_REPLY;
		default: state_nxt = S_IDLE;
		endcase
	end

	always @(posedge clock_i) begin
		if (sys_rst_i) begin
			state_r       <= S_IDLE;
			rx_cnt_r      <= 4'h0;
			rx_sh_r       <= 64'h0;
			host_frm_r    <= 72'h0;
			host_pend_r   <= 1'b0;
			src_host_r    <= 1'b0;
			code_r        <= 8'h00;
			type_r        <= 8'h00;
			bank_r        <= 8'h00;
			val_r         <= {DW{1'b0}};
			op_a_r        <= {DW{1'b0}};
			tx_sh_r       <= 72'h0;
			tx_cnt_r      <= 4'h0;
			irq_pend_r    <= 1'b0;
			vec0_def_r    <= 1'b0;
			sv_acc_r      <= {DW{1'b0}};
			sv_x_r        <= {DW{1'b0}};
			sv_flags_r    <= 2'b00;
			sv_pc_r       <= {DW{1'b0}};
			instr_ready_o <= 1'b0;
			acc_o         <= {DW{1'b0}};
			x_o           <= {DW{1'b0}};
			flags_o       <= 2'b00;
			pc_o          <= {DW{1'b0}};
			in_handler_o  <= 1'b0;
			tx_byte_o     <= 8'h00;
			tx_valid_o    <= 1'b0;
		end else begin
			state_r       <= state_nxt;
			instr_ready_o <= (state_nxt == S_IDLE);
			tx_valid_o    <= 1'b0;
			if (acc_wr_i) begin
				acc_o <= acc_wr_data_i;
			end
			if (x_wr_i) begin
				x_o <= x_wr_data_i;
			end
			// Frame assembly; a completed frame for DEV_ADDR replaces any unserved one
			if (rx_valid_i) begin
				rx_sh_r  <= {rx_sh_r[55:0], rx_byte_i};
				rx_cnt_r <= frm_done ? 4'h0 : rx_cnt_r + 4'h1;
			end
			if (timer0_event_i) begin
				irq_pend_r <= 1'b1;
			end
			case (state_r)
			S_IDLE: begin
				code_r     <= sel_code;
				type_r     <= sel_type;
				bank_r     <= sel_bank;
				val_r      <= sel_val;
				src_host_r <= sel_host;
				if (sel_host) begin
					host_pend_r <= 1'b0;
					if (!frm_ok) begin
						tx_sh_r <= mk_reply(`ST_BAD_CHECKSUM, sel_code);
					end else if (is_calc || sel_code == `CMD_DEFINE_HANDLER ||
					             sel_code == `CMD_HANDLER_RETURN) begin
						tx_sh_r <= mk_reply(`ST_OK, sel_code);
					end else begin
						tx_sh_r <= mk_reply(`ST_BAD_CMD, sel_code);
					end
				end else if (take_irq) begin
					sv_acc_r     <= acc_o;
					sv_x_r       <= x_o;
					sv_flags_r   <= flags_o;
					sv_pc_r      <= pc_o;
					in_handler_o <= 1'b1;
					irq_pend_r   <= timer0_event_i;
				end else if (take_ins) begin
					pc_o <= pc_o + {{(DW-1){1'b0}}, 1'b1};
					if (sel_code == `CMD_DEFINE_HANDLER && sel_type == `IRQ_TIMER0) begin
						vec0_def_r <= 1'b1;
					end
					if (sel_code == `CMD_HANDLER_RETURN && in_handler_o) begin
						acc_o        <= sv_acc_r;
						x_o          <= sv_x_r;
						flags_o      <= sv_flags_r;
						pc_o         <= sv_pc_r;
						in_handler_o <= 1'b0;
					end
				end
			end
			S_RD2: begin
				op_a_r <= var_rd;
			end
			S_EX: begin
				if (type_r == `OP_COMP) begin
					flags_o[`FLAG_EQ] <= (ex_a == ex_b);
					flags_o[`FLAG_LT] <= ($signed(ex_a) < $signed(ex_b));
				end else if (!is_vv && type_r == `OP_SWAP) begin
					acc_o <= ex_a;
				end
				// Two-variable math touches neither accumulator nor X
			end
			S_IRQ: begin
				pc_o <= vec_rd;
			end
			S_REPLY: begin
				tx_valid_o <= 1'b1;
				tx_byte_o  <= tx_sh_r[71:64];
				tx_sh_r    <= {tx_sh_r[63:0], 8'h00};
				tx_cnt_r   <= (tx_cnt_r == `FRAME_LAST) ? 4'h0 : tx_cnt_r + 4'h1;
			end
			default: begin
			end
			endcase
			// Target address filter on completed frames
			if (frm_done && rx_sh_r[63:56] == DEV_ADDR) begin
				host_frm_r  <= {rx_sh_r, rx_byte_i};
				host_pend_r <= 1'b1;
			end
		end
	end
endmodule

/* File: rtl/word_ram.v */
// Small synchronous memory: one write port, one read port.
// Read data comes out of a register one clock after the address.
module word_ram #(
	parameter AW = 8,
	parameter DW = 32
) (
	input  wire          clock_i,
	input  wire          sys_rst_i,
	input  wire          wr_en_i,
	input  wire [AW-1:0] wr_addr_i,
	input  wire [DW-1:0] wr_data_i,
	input  wire [AW-1:0] rd_addr_i,
	output wire [DW-1:0] rd_data_o
);
	reg [DW-1:0] mem_r [0:(1<<AW)-1];
	reg [DW-1:0] rd_data_r;

	always @(posedge clock_i) begin
		if (wr_en_i) begin
			mem_r[wr_addr_i] <= wr_data_i;
		end
	end

	always @(posedge clock_i) begin
		if (sys_rst_i) begin
			rd_data_r <= {DW{1'b0}};
		end else begin
			rd_data_r <= mem_r[rd_addr_i];
		end
	end

	assign rd_data_o = rd_data_r;
endmodule

/* File: test/calc_core_properties.sv */
// Checker for the command core: reply framing, calc side effects, handler entry/exit.
// Assumes binding to vector_calc_core; one clock, synchronous active-high reset.
module calc_core_properties #(
	parameter [7:0] DEV_ADDR = 8'h01
) (
	input wire logic        clock_i,
	input wire logic        sys_rst_i,
	input wire logic        instr_valid_i,
	input wire logic [7:0]  instr_code_i,
	input wire logic        timer0_event_i,
	input wire logic        irq_global_en_i,
	input wire logic        irq_timer0_en_i,
	input wire logic        instr_ready_o,
	input wire logic [31:0] acc_o,
	input wire logic [31:0] x_o,
	input wire logic [1:0]  flags_o,
	input wire logic [31:0] pc_o,
	input wire logic        in_handler_o,
	input wire logic [7:0]  tx_byte_o,
	input wire logic        tx_valid_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0]  cnt_r;
	logic [7:0]  sum_r;
	logic [31:0] pc_sv_r, acc_sv_r, x_sv_r;
	logic [1:0]  fl_sv_r;
	wire         take = instr_valid_i && instr_ready_o;
	// Running reply sum, and context as it stood before handler entry
	always @(posedge clock_i) begin
		if (sys_rst_i || !tx_valid_o) begin
			cnt_r <= 4'h0;
			sum_r <= 8'h00;
		end else begin
			cnt_r <= cnt_r + 4'h1;
			sum_r <= sum_r + tx_byte_o;
		end
		if (!in_handler_o) begin
			pc_sv_r <= pc_o;
			acc_sv_r <= acc_o;
			x_sv_r <= x_o;
			fl_sv_r <= flags_o;
		end
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	chk_reply_length: assert property ($rose(tx_valid_o) |-> tx_valid_o[*8] ##1 tx_valid_o ##1 !tx_valid_o)
		else $error("reply is not nine bytes");
	chk_reply_head: assert property ($rose(tx_valid_o) |-> tx_byte_o == 8'h02 ##1 tx_byte_o == DEV_ADDR)
		else $error("reply addresses wrong");
	chk_reply_sum: assert property (tx_valid_o && cnt_r == 4'h8 |-> tx_byte_o == sum_r)
		else $error("reply checksum wrong");
	chk_reply_value: assert property ($rose(tx_valid_o) |-> ##4 (tx_byte_o == 8'h00)[*4])
		else $error("reply value not zero");
	chk_calc_keeps_acc: assert property (take && instr_code_i == 8'h28 |=> ($stable(acc_o) && $stable(x_o))[*4])
		else $error("two-variable calc touched acc or x");
	chk_pc_step: assert property (take && (instr_code_i == 8'h28 || instr_code_i == 8'h29) |=> pc_o == $past(pc_o) + 32'h1)
		else $error("pc did not advance");
	chk_return_restore: assert property ($fell(in_handler_o) |-> pc_o == pc_sv_r && acc_o == acc_sv_r && x_o == x_sv_r && flags_o == fl_sv_r)
		else $error("context not restored");
	chk_return_ends: assert property (take && in_handler_o && instr_code_i == 8'h26 |=> !in_handler_o)
		else $error("handler return ignored");
	chk_irq_entry: assert property (timer0_event_i && irq_global_en_i && irq_timer0_en_i && !in_handler_o |-> ##[1:8] in_handler_o)
		else $error("timer event not entered");
	chk_irq_blocked: assert property (!irq_global_en_i && !in_handler_o |=> !in_handler_o)
		else $error("entry while globally disabled");
	cover property (take && instr_code_i == 8'h28);
	cover property ($fell(in_handler_o));
	cover property ($rose(tx_valid_o));
endmodule

/* File: test/host_model.sv */
// Host side: sends nine-byte command frames, collects reply bytes.
// Assumes reply bytes come one per clock while tx_valid_i is high.
module host_model (
	input  wire logic       clock_i,
	input  wire logic [7:0] tx_byte_i,
	input  wire logic       tx_valid_i,
	output logic      [7:0] rx_byte_o,
	output logic            rx_valid_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rep [0:8];
	int         rep_n = 0;
	initial begin
		rx_byte_o = 8'h00;
		rx_valid_o = 1'b0;
	end
	always @(posedge clock_i) begin
		if (tx_valid_i && rep_n < 9) begin
			rep[rep_n] <= tx_byte_i;
			rep_n <= rep_n + 1;
		end
	end
	// Bad flag corrupts the checksum on purpose
	task automatic send_frame(input logic [7:0] tgt, code, typ, bank, input logic [31:0] val,
			input logic bad);
		logic [63:0] w;
		logic [7:0]  s, b;
		w = {tgt, code, typ, bank, val};
		s = 8'h00;
		rep_n = 0;
		for (int i = 0; i < 9; i++) begin
			@(posedge clock_i);
			b = (i < 8) ? w[63 - 8 * i -: 8] : s ^ {7'h00, bad};
			if (i < 8) s = s + b;
			rx_byte_o <= b;
			rx_valid_o <= 1'b1;
		end
		@(posedge clock_i);
		rx_valid_o <= 1'b0;
		rx_byte_o <= ~b;
	endtask
endmodule

/* File: test/testbench.sv */
// Testbench for the command core: instruction port, host frames, timer handler.
// Assumes the host model is the only source of receive bytes.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        ivalid = 1'b0, tmr = 1'b0, gen = 1'b0, ten = 1'b0, awr = 1'b0, xwr = 1'b0;
	logic [7:0]  icode = 8'h00, itype = 8'h00, ibank = 8'h00;
	logic [31:0] ival = 32'h0, adata = 32'h0, xdata = 32'h0;
	wire  [7:0]  rxb, txb;
	wire         rxv, txv, ready, inh;
	wire  [31:0] acc, xr, pc;
	wire  [1:0]  flags;
	int          fails = 0, n_tests = 0;
	always #5 clock_i = ~clock_i;
	vector_calc_core #(.DEV_ADDR(8'h01)) DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
		.rx_byte_i(rxb), .rx_valid_i(rxv), .instr_valid_i(ivalid), .instr_code_i(icode),
		.instr_type_i(itype), .instr_bank_i(ibank), .instr_value_i(ival),
		.timer0_event_i(tmr), .irq_global_en_i(gen), .irq_timer0_en_i(ten), .acc_wr_i(awr),
		.acc_wr_data_i(adata), .x_wr_i(xwr), .x_wr_data_i(xdata), .instr_ready_o(ready),
		.acc_o(acc), .x_o(xr), .flags_o(flags), .pc_o(pc), .in_handler_o(inh),
		.tx_byte_o(txb), .tx_valid_o(txv));
	host_model host (.clock_i(clock_i), .tx_byte_i(txb), .tx_valid_i(txv), .rx_byte_o(rxb),
		.rx_valid_o(rxv));
	task automatic check(input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic timeout;
		fails++;
		$display("ERROR %0t: wait ran out", $time);
		end_of_test();
	endtask
	task automatic wait_ready;
		int k;
		for (k = 0; k < 20 && ready !== 1'b1; k++) @(posedge clock_i);
		if (k == 20) timeout();
	endtask
	task automatic instr(input logic [7:0] c, t, b, input logic [31:0] v);
		wait_ready();
		icode <= c;
		itype <= t;
		ibank <= b;
		ival <= v;
		ivalid <= 1'b1;
		@(posedge clock_i);
		ivalid <= 1'b0;
		repeat (2) @(posedge clock_i);
		wait_ready();
	endtask
	task automatic setacc(input logic [31:0] v);
		awr <= 1'b1;
		adata <= v;
		@(posedge clock_i);
		awr <= 1'b0;
		@(posedge clock_i);
	endtask
	task automatic wait_reply;
		int k;
		for (k = 0; k < 40 && host.rep_n != 9; k++) @(posedge clock_i);
		if (k == 40) timeout();
	endtask
	// Var 10h = 3, var 11h = 5, every op code and one undefined
	task automatic calc_ops;
		logic [31:0] exp [0:12];
		exp = '{32'h8, 32'hFFFFFFFE, 32'hF, 32'h0, 32'h3, 32'h1, 32'h7, 32'h6, 32'hFFFFFFFA,
			32'h5, 32'h5, 32'h3, 32'h3};
		for (int op = 0; op < 13; op++) begin
			setacc(32'h3);
			instr(8'h29, 8'h09, 8'h10, 32'h0);
			setacc(32'h5);
			instr(8'h29, 8'h09, 8'h11, 32'h0);
			instr(8'h28, op[7:0], 8'h10, 32'h11);
			check(acc, 32'h5);
			check(xr, 32'h0);
			if (op == 11) check({30'h0, flags}, 32'h2);
			instr(8'h29, 8'h0A, 8'h10, 32'h0);
			check(acc, exp[op]);
		end
	endtask
	task automatic accu_ops;
		setacc(32'h9);
		instr(8'h29, 8'h09, 8'h20, 32'h0);
		setacc(32'h4);
		instr(8'h29, 8'h01, 8'h20, 32'hFFFFFFFF);
		check(acc, 32'h4);
		instr(8'h29, 8'h0A, 8'h20, 32'h0);
		check(acc, 32'h5);
		instr(8'h29, 8'h08, 8'h20, 32'h0);
		instr(8'h29, 8'h0A, 8'h20, 32'h0);
		check(acc, 32'hFFFFFFFA);
	endtask
	task automatic host_frames;
		logic [7:0] cd, st;
		for (int i = 0; i < 5; i++) begin
			cd = (i == 0) ? 8'h25 : (i == 1) ? 8'h26 : (i == 3) ? 8'h29 : 8'h28;
			st = (i < 4) ? 8'h64 : 8'h01;
			host.send_frame(8'h01, cd, 8'h09, 8'h30, 32'h31, i == 4);
			wait_reply();
			check(host.rep[2], st);
			check(host.rep[3], cd);
			check(host.rep[8], 8'h03 + st + cd);
		end
		host.send_frame(8'h07, 8'h28, 8'h09, 8'h30, 32'h31, 1'b0);
		repeat (30) @(posedge clock_i);
		check(host.rep_n, 32'h0);
	endtask
	task automatic irq_flow;
		logic [31:0] pc_before;
		int          k;
		instr(8'h25, 8'h00, 8'h00, 32'h32);
		instr(8'h25, 8'h00, 8'h07, 32'h40);
		instr(8'h25, 8'hFF, 8'h00, 32'h77);
		host.send_frame(8'h01, 8'h25, 8'h00, 8'h00, 32'h99, 1'b0);
		wait_reply();
		setacc(32'h7);
		xwr <= 1'b1;
		xdata <= 32'h9;
		gen <= 1'b1;
		ten <= 1'b1;
		@(posedge clock_i);
		xwr <= 1'b0;
		tmr <= 1'b1;
		pc_before = pc;
		@(posedge clock_i);
		tmr <= 1'b0;
		for (k = 0; k < 10 && inh !== 1'b1; k++) @(posedge clock_i);
		if (k == 10) timeout();
		@(posedge clock_i);
		check(pc, 32'h40);
		setacc(32'h1);
		instr(8'h26, 8'hFF, 8'h00, 32'h0);
		check(inh, 32'h0);
		check(acc, 32'h7);
		check(xr, 32'h9);
		check(pc, pc_before);
		gen <= 1'b0;
		@(posedge clock_i);
		tmr <= 1'b1;
		@(posedge clock_i);
		tmr <= 1'b0;
		repeat (10) @(posedge clock_i);
		check(inh, 32'h0);
	endtask
	initial begin
		repeat (2) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		@(posedge clock_i);
		calc_ops();
		accu_ops();
		host_frames();
		irq_flow();
		end_of_test();
	end
endmodule

bind vector_calc_core calc_core_properties #(.DEV_ADDR(DEV_ADDR)) u_props (
	.clock_i(clock_i), .sys_rst_i(sys_rst_i), .instr_valid_i(instr_valid_i),
	.instr_code_i(instr_code_i), .timer0_event_i(timer0_event_i),
	.irq_global_en_i(irq_global_en_i), .irq_timer0_en_i(irq_timer0_en_i),
	.instr_ready_o(instr_ready_o), .acc_o(acc_o), .x_o(x_o), .flags_o(flags_o), .pc_o(pc_o),
	.in_handler_o(in_handler_o), .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o));
